// [rtl/fpc_pkg.sv]
// Purpose: Shared constants for the fault, PDM and clock-ratio register bank
// Assumes: Byte-wide register port decoded from the control-bus slave
// Notes: Offsets are the printed register addresses
package fpc_pkg;
    localparam logic [7:0] FPC_ADDR_FAULT = 8'h12;
    localparam logic [7:0] FPC_ADDR_PDM = 8'h13;
    localparam logic [7:0] FPC_ADDR_RATIO = 8'h14;
    localparam logic [7:0] FPC_RST_FAULT = 8'h30;
    localparam logic [7:0] FPC_RST_PDM = 8'h40;
    localparam logic [7:0] FPC_RST_RATIO = 8'h11;
    // Fault register fields
    localparam int FPC_GAIN_LSB = 6;
    localparam int FPC_LIMIT_LSB = 4;
    localparam int FPC_STROBE_BIT = 3;
    localparam int FPC_UV_BIT = 2;
    localparam int FPC_OT_BIT = 1;
    localparam int FPC_OC_BIT = 0;
    // Only the stored bits of the fault register; bit 3 is write-only
    localparam logic [7:0] FPC_FAULT_MASK = 8'hF7;
    // PDM register fields
    localparam int FPC_PICK_BIT = 7;
    localparam int FPC_PAT_BIT = 6;
    localparam int FPC_ASRC_BIT = 4;
    localparam int FPC_LAT_LSB = 2;
    localparam int FPC_SHARE_BIT = 1;
    localparam int FPC_VBAT_BIT = 0;
    localparam logic [7:0] FPC_PDM_MASK = 8'hDF;
    // Ratio register fields
    localparam int FPC_AUTO_BIT = 4;
    localparam logic [7:0] FPC_RATIO_MASK = 8'h1F;
    // Control-bus addresses in PDM mode
    localparam logic [6:0] FPC_BUS_ADDR_LO = 7'h34;
    localparam logic [6:0] FPC_BUS_ADDR_HI = 7'h35;
    // Gain cut in units of 0.125 dB: 0, 1.5, 3, 5.625 dB
    localparam logic [5:0] FPC_CUT_0 = 6'h00;
    localparam logic [5:0] FPC_CUT_1 = 6'h0C;
    localparam logic [5:0] FPC_CUT_2 = 6'h18;
    localparam logic [5:0] FPC_CUT_3 = 6'h2D;
    // Attempt limits; zero means unlimited
    localparam logic [3:0] FPC_TRY_0 = 4'h1;
    localparam logic [3:0] FPC_TRY_1 = 4'h3;
    localparam logic [3:0] FPC_TRY_2 = 4'h7;
    localparam logic [3:0] FPC_TRY_3 = 4'h0;
    typedef enum logic [1:0] {
        FPC_LAT_NORMAL,
        FPC_LAT_15US,
        FPC_LAT_5US,
        FPC_LAT_RSVD
    } fpc_lat_e;
endpackage

// [rtl/fpc_regs.sv]
// Purpose: Fault recovery, PDM interface and clock-ratio configuration registers
// Assumes: Byte register port from the control-bus slave, inputs synchronous to clk_sys
// Notes: Decoded controls feed the fault, PDM and clocking logic outside
//
// Notes on behaviour
// - On a thermal warning the gain is cut by 0, 1.5, 3 or 5.625 dB per a two-bit field.
// - A two-bit field caps auto recovery attempts at 1, 3, 7 or unlimited, reset unlimited.
// - Writing one to the write-only strobe starts one attempt per fault class that was set to manual before that write.
// - The undervoltage control bit picks auto recovery when clear, manual when set.
// - The overtemperature control bit picks auto recovery when clear, manual when set.
// - The overcurrent control bit picks auto recovery when clear, manual when set.
// - With the mode strap high the pick bit selects the left channel at zero, right at one.
// - With the strap low the pattern enable bit allows pattern configuration, reset enabled.
// - In PDM mode with strap low the bus address is 0x34, or follows the pin when the bit is set.
// - A two-bit latency field picks normal, about 15 us or about 5 us delay paths.
// - With clock share set the playback PDM clock also drives the sense output.
// - In PDM mode the sense output carries output voltage at zero and battery at one.
// - With auto ratio set the detected code is stored for readback, else the written code is used.
// - The ratio code means 64, 128, 192, 256 or 384 times the sample rate.
`timescale 1ns/10ps
module fpc_regs
    import fpc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic mode_strap,
    input wire logic pdm_mode,
    input wire logic channel_address_pin,
    input wire logic thermal_warning,
    input wire logic ratio_detect_valid,
    input wire logic [3:0] ratio_detect_code,
    output logic [5:0] gain_cut_eighth_db,
    output logic [3:0] recovery_attempt_max,
    output logic undervolt_recovery_manual,
    output logic overtemp_recovery_manual,
    output logic overcurrent_recovery_manual,
    output logic recover_uv_pulse,
    output logic recover_ot_pulse,
    output logic recover_oc_pulse,
    output logic pdm_right_channel,
    output logic pattern_config_allowed,
    output logic [6:0] bus_address,
    output logic [1:0] latency_path,
    output logic sense_clock_from_playback,
    output logic sense_battery,
    output logic [3:0] clock_ratio_in_use
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] fault;
        logic [7:0] pdm;
        logic [7:0] ratio;
        logic [7:0] rdata;
        logic [2:0] rec_pulse;
        logic [5:0] cut;
    } fpc_state_s;

    fpc_state_s st;
    fpc_state_s next_st;

    function automatic logic [5:0] cut_of(input logic [1:0] code);
        case (code)
            2'b00: cut_of = FPC_CUT_0;
            2'b01: cut_of = FPC_CUT_1;
            2'b10: cut_of = FPC_CUT_2;
            default: cut_of = FPC_CUT_3;
        endcase
    endfunction

    function automatic logic [3:0] tries_of(input logic [1:0] code);
        case (code)
            2'b00: tries_of = FPC_TRY_0;
            2'b01: tries_of = FPC_TRY_1;
            2'b10: tries_of = FPC_TRY_2;
            default: tries_of = FPC_TRY_3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.rec_pulse = 3'b000;
        if (reg_write) begin
            case (reg_addr)
                FPC_ADDR_FAULT: begin
                    next_st.fault = reg_wdata & FPC_FAULT_MASK;
                    if (reg_wdata[FPC_STROBE_BIT]) begin
                        next_st.rec_pulse = {st.fault[FPC_UV_BIT], st.fault[FPC_OT_BIT],
                                             st.fault[FPC_OC_BIT]};
                    end
                end
                FPC_ADDR_PDM: begin
                    next_st.pdm = reg_wdata & FPC_PDM_MASK;
                end
                FPC_ADDR_RATIO: begin
                    next_st.ratio = reg_wdata & FPC_RATIO_MASK;
                end
                default: begin
                    next_st.rdata = st.rdata;
                end
            endcase
        end
        // detected code stored; detector wins over a same-cycle write
        if (st.ratio[FPC_AUTO_BIT] && ratio_detect_valid) begin
            next_st.ratio[3:0] = ratio_detect_code;
        end
        next_st.cut = thermal_warning ? cut_of(st.fault[FPC_GAIN_LSB +: 2]) : FPC_CUT_0;
        if (reg_read) begin
            case (reg_addr)
                FPC_ADDR_FAULT: next_st.rdata = st.fault;
                FPC_ADDR_PDM: next_st.rdata = st.pdm;
                FPC_ADDR_RATIO: next_st.rdata = st.ratio;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '{fault: FPC_RST_FAULT, pdm: FPC_RST_PDM, ratio: FPC_RST_RATIO,
                    rdata: 8'h00, rec_pulse: 3'b000, cut: 6'h00};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulses are gated by clk_en so a frozen block cannot repeat a strobe
    assign reg_rdata = st.rdata;
    assign gain_cut_eighth_db = st.cut;
    assign recovery_attempt_max = tries_of(st.fault[FPC_LIMIT_LSB +: 2]);
    assign undervolt_recovery_manual = st.fault[FPC_UV_BIT];
    assign overtemp_recovery_manual = st.fault[FPC_OT_BIT];
    assign overcurrent_recovery_manual = st.fault[FPC_OC_BIT];
    assign recover_uv_pulse = st.rec_pulse[2] & clk_en;
    assign recover_ot_pulse = st.rec_pulse[1] & clk_en;
    assign recover_oc_pulse = st.rec_pulse[0] & clk_en;
    assign pdm_right_channel = mode_strap & st.pdm[FPC_PICK_BIT];
    assign pattern_config_allowed = ~mode_strap & st.pdm[FPC_PAT_BIT];
    assign bus_address = (pdm_mode && !mode_strap && st.pdm[FPC_ASRC_BIT] && channel_address_pin)
                         ? FPC_BUS_ADDR_HI : FPC_BUS_ADDR_LO;
    assign latency_path = st.pdm[FPC_LAT_LSB +: 2];
    assign sense_clock_from_playback = st.pdm[FPC_SHARE_BIT];
    assign sense_battery = pdm_mode & st.pdm[FPC_VBAT_BIT];
    assign clock_ratio_in_use = st.ratio[3:0];

    ////////////////////////////////////////////////////////////////////////////
    property p_strobe;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_FAULT && reg_wdata[3]) |=>
            (st.rec_pulse == {$past(st.fault[2]), $past(st.fault[1]), $past(st.fault[0])});
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pulses wrong");

    property p_no_strobe;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && !(reg_write && reg_addr == FPC_ADDR_FAULT && reg_wdata[3])) |=>
            (st.rec_pulse == 3'b000);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("spurious recovery");

    property p_cut;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && thermal_warning && st.fault[7:6] == 2'b11) |=> (gain_cut_eighth_db == FPC_CUT_3);
    endproperty
    a_cut: assert property (p_cut) else $error("gain cut wrong");

    property p_tries;
        @(posedge clk_sys) disable iff (reset)
        (st.fault[5:4] == 2'b10) |-> (recovery_attempt_max == FPC_TRY_2);
    endproperty
    a_tries: assert property (p_tries) else $error("attempt cap wrong");

    property p_rsvd;
        @(posedge clk_sys) disable iff (reset)
        (st.fault[3] == 1'b0) && (st.pdm[5] == 1'b0) && (st.ratio[7:5] == 3'b000);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_uv;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_FAULT) |=>
            (undervolt_recovery_manual == $past(reg_wdata[2]));
    endproperty
    a_uv: assert property (p_uv) else $error("uv control not stored");

    property p_auto;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && st.ratio[4] && ratio_detect_valid) |=>
            (clock_ratio_in_use == $past(ratio_detect_code));
    endproperty
    a_auto: assert property (p_auto) else $error("detected ratio lost");

    property p_addr;
        @(posedge clk_sys) disable iff (reset)
        (pdm_mode && !mode_strap && !st.pdm[4]) |-> (bus_address == FPC_BUS_ADDR_LO);
    endproperty
    a_addr: assert property (p_addr) else $error("bus address wrong");

    property p_read;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_read && reg_addr == FPC_ADDR_PDM && !reg_write) |=>
            (reg_rdata == $past(st.pdm));
    endproperty
    a_read: assert property (p_read) else $error("pdm readback wrong");

    property p_cut_none;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && !thermal_warning) |=> (gain_cut_eighth_db == FPC_CUT_0);
    endproperty
    a_cut_none: assert property (p_cut_none) else $error("cut without warning");

    property p_cut_low;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && thermal_warning && st.fault[FPC_GAIN_LSB +: 2] == 2'h1) |=>
            (gain_cut_eighth_db == FPC_CUT_1);
    endproperty
    a_cut_low: assert property (p_cut_low) else $error("small gain cut wrong");

    property p_tries_one;
        @(posedge clk_sys) disable iff (reset)
        (st.fault[FPC_LIMIT_LSB +: 2] == 2'h0) |-> (recovery_attempt_max == FPC_TRY_0);
    endproperty
    a_tries_one: assert property (p_tries_one) else $error("single attempt cap wrong");

    property p_tries_free;
        @(posedge clk_sys) disable iff (reset)
        (st.fault[FPC_LIMIT_LSB +: 2] == 2'h3) |-> (recovery_attempt_max == FPC_TRY_3);
    endproperty
    a_tries_free: assert property (p_tries_free) else $error("unlimited cap wrong");

    property p_ot;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_FAULT) |=>
            (overtemp_recovery_manual == $past(reg_wdata[FPC_OT_BIT]));
    endproperty
    a_ot: assert property (p_ot) else $error("ot control not stored");

    property p_oc;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_FAULT) |=>
            (overcurrent_recovery_manual == $past(reg_wdata[FPC_OC_BIT]));
    endproperty
    a_oc: assert property (p_oc) else $error("oc control not stored");

    property p_pick;
        @(posedge clk_sys) disable iff (reset)
        mode_strap |-> (pdm_right_channel == st.pdm[FPC_PICK_BIT]);
    endproperty
    a_pick: assert property (p_pick) else $error("channel pick wrong");

    property p_pattern;
        @(posedge clk_sys) disable iff (reset)
        !mode_strap |-> (pattern_config_allowed == st.pdm[FPC_PAT_BIT]);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern enable wrong");

    property p_addr_pin;
        @(posedge clk_sys) disable iff (reset)
        (pdm_mode && !mode_strap && st.pdm[FPC_ASRC_BIT]) |->
            (bus_address == (channel_address_pin ? FPC_BUS_ADDR_HI : FPC_BUS_ADDR_LO));
    endproperty
    a_addr_pin: assert property (p_addr_pin) else $error("pin address wrong");

    property p_latency;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_PDM) |=>
            (latency_path == $past(reg_wdata[FPC_LAT_LSB +: 2]));
    endproperty
    a_latency: assert property (p_latency) else $error("latency path wrong");

    property p_share;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_write && reg_addr == FPC_ADDR_PDM) |=>
            (sense_clock_from_playback == $past(reg_wdata[FPC_SHARE_BIT]));
    endproperty
    a_share: assert property (p_share) else $error("clock share wrong");

    property p_sense;
        @(posedge clk_sys) disable iff (reset)
        pdm_mode |-> (sense_battery == st.pdm[FPC_VBAT_BIT]);
    endproperty
    a_sense: assert property (p_sense) else $error("sense select wrong");

    property p_manual_ratio;
        @(posedge clk_sys) disable iff (reset)
        (clk_en && !st.ratio[FPC_AUTO_BIT] && reg_write && reg_addr == FPC_ADDR_RATIO) |=>
            (clock_ratio_in_use == $past(reg_wdata[3:0]));
    endproperty
    a_manual_ratio: assert property (p_manual_ratio) else $error("written ratio lost");

    property p_frozen_pulse;
        @(posedge clk_sys) disable iff (reset)
        !clk_en |-> ({recover_uv_pulse, recover_ot_pulse, recover_oc_pulse} == 3'h0);
    endproperty
    a_frozen_pulse: assert property (p_frozen_pulse) else $error("pulse while frozen");

endmodule

// [tb/fpc_host.sv]
// Purpose: Host model driving the byte register port of the bank
// Assumes: One request at a time, launched just after a rising edge
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/10ps
module fpc_host (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // strobe and share set by write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the configuration register bank
// Assumes: Host model owns the register port
// Notes: Expected values come from the field encodings
`timescale 1ns/10ps
module tb
    import fpc_pkg::*;
;
    logic clk_sys, reset, clk_en, mode_strap, pdm_mode, pin, warn, rvalid;
    logic [3:0] rcode, tries, ratio;
    logic [7:0] addr, wdata, rdata;
    logic wr_en, rd_en, uv, ot, oc, p_uv, p_ot, p_oc, right, pat, share, vbat;
    logic [5:0] cut;
    logic [6:0] bus;
    logic [1:0] lat;
    int n_fail = 0;
    int num_checks = 0;
    fpc_regs dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr_en), .reg_read(rd_en), .reg_rdata(rdata),
        .mode_strap(mode_strap), .pdm_mode(pdm_mode), .channel_address_pin(pin),
        .thermal_warning(warn), .ratio_detect_valid(rvalid), .ratio_detect_code(rcode),
        .gain_cut_eighth_db(cut), .recovery_attempt_max(tries),
        .undervolt_recovery_manual(uv), .overtemp_recovery_manual(ot),
        .overcurrent_recovery_manual(oc), .recover_uv_pulse(p_uv), .recover_ot_pulse(p_ot),
        .recover_oc_pulse(p_oc), .pdm_right_channel(right), .pattern_config_allowed(pat),
        .bus_address(bus), .latency_path(lat), .sense_clock_from_playback(share),
        .sense_battery(vbat), .clock_ratio_in_use(ratio));
    fpc_host host (.clk_sys(clk_sys), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr_en), .reg_read(rd_en), .reg_rdata(rdata));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.rd(a, v);
        chk("rdata", v, e);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_fault;
        logic [5:0] cuts [4] = '{FPC_CUT_0, FPC_CUT_1, FPC_CUT_2, FPC_CUT_3};
        logic [3:0] lims [4] = '{FPC_TRY_0, FPC_TRY_1, FPC_TRY_2, FPC_TRY_3};
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h12, {i[1:0], i[1:0], 4'hF});
            @(negedge clk_sys);
            chk("cut", 8'(cut), 8'(cuts[i]));
            chk("tries", 8'(tries), 8'(lims[i]));
            rchk(8'h12, {i[1:0], i[1:0], 4'h7});
        end
        @(posedge clk_sys);
        warn <= 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("cut off", 8'(cut), 8'h00);
        host.wr(8'h12, 8'h0D);
        chk("pulse", 8'({p_uv, p_ot, p_oc}), 8'h07);
        @(negedge clk_sys);
        chk("pulse end", 8'({p_uv, p_ot, p_oc}), 8'h00);
        chk("manual", 8'({uv, ot, oc}), 8'h05);
        host.wr(8'h12, 8'h08);
        chk("pulse", 8'({p_uv, p_ot, p_oc}), 8'h05);
        host.wr(8'h12, 8'h03);
        host.wr(8'h12, 8'h00);
        chk("no pulse", 8'({p_uv, p_ot, p_oc}), 8'h00);
    endtask
    task automatic t_pdm;
        @(posedge clk_sys);
        mode_strap <= 1'b1;
        host.wr(8'h13, 8'hFF);
        rchk(8'h13, 8'hDF);
        chk("pick", 8'({right, pat}), 8'h02);
        chk("bus", 8'(bus), 8'h34);
        chk("sense off", 8'(vbat), 8'h00);
        @(posedge clk_sys);
        mode_strap <= 1'b0;
        pdm_mode <= 1'b1;
        pin <= 1'b1;
        host.wr(8'h13, 8'hD9);
        chk("bus", 8'(bus), 8'h35);
        chk("pick", 8'({right, pat}), 8'h01);
        chk("path", 8'({lat, share, vbat}), 8'h09);
        host.wr(8'h13, 8'h06);
        chk("bus", 8'(bus), 8'h34);
        chk("path", 8'({lat, share, vbat}), 8'h06);
        chk("pick", 8'({right, pat}), 8'h00);
    endtask
    task automatic t_ratio;
        host.wr(8'h14, 8'hE3);
        rchk(8'h14, 8'h03);
        @(posedge clk_sys);
        rvalid <= 1'b1;
        rcode <= 4'h4;
        host.wr(8'h20, 8'hFF);
        @(posedge clk_sys);
        rvalid <= 1'b0;
        chk("manual ratio", 8'(ratio), 8'h03);
        rchk(8'h20, 8'h00);
        host.wr(8'h14, 8'h10);
        @(posedge clk_sys);
        rvalid <= 1'b1;
        rcode <= 4'h2;
        @(posedge clk_sys);
        rvalid <= 1'b0;
        @(negedge clk_sys);
        chk("auto ratio", 8'(ratio), 8'h02);
        rchk(8'h14, 8'h12);
        // Frozen clock enable must drop the write
        @(posedge clk_sys);
        clk_en <= 1'b0;
        host.wr(8'h14, 8'h04);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rchk(8'h14, 8'h12);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
    initial begin
        {reset, clk_en, warn} = 3'b111;
        {mode_strap, pdm_mode, pin, rvalid, rcode} = 8'h00;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(8'h12, 8'h30);
        rchk(8'h13, 8'h40);
        rchk(8'h14, 8'h11);
        chk("reset tries", 8'(tries), 8'(FPC_TRY_3));
        t_fault();
        t_pdm();
        t_ratio();
        end_sim();
    end
endmodule
